// ==== rtl/spc_defines.svh ====
// register map, field positions and reset values of the serial port pin control block
// assumes inclusion by bare name from the block's design file
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH
`define SPC_ADDR_W 8
`define SPC_DATA_W 16
`define SPC_ADDR_TX_CHAN_EN_B 8'h11
`define SPC_ADDR_PIN_CONTROL 8'h12
`define SPC_ADDR_RX_CHAN_EN_C 8'h13
`define SPC_ADDR_MODE_CONTROL 8'h20
`define SPC_ADDR_GEN_CONFIG 8'h21
`define SPC_ADDR_STATUS 8'h22
`define SPC_RST_TX_CHAN_EN_B 16'h0000
`define SPC_RST_PIN_CONTROL 16'h0000
`define SPC_RST_RX_CHAN_EN_C 16'h0000
`define SPC_RST_MODE_CONTROL 16'h0000
`define SPC_RST_GEN_CONFIG 16'h0000
`define SPC_PIN_CONTROL_WMASK 16'h0F8F
`define SPC_MODE_CONTROL_WMASK 16'h00FF
`define SPC_GEN_CONFIG_WMASK 16'h01FF
`define SPC_PCR_TX_FSYNC_MODE 11
`define SPC_PCR_RX_FSYNC_MODE 10
`define SPC_PCR_TX_CLOCK_MODE 9
`define SPC_PCR_RX_CLOCK_MODE 8
`define SPC_PCR_GEN_INPUT_MODE_EXT 7
`define SPC_PCR_TX_FSYNC_POL 3
`define SPC_PCR_RX_FSYNC_POL 2
`define SPC_PCR_TX_CLOCK_POL 1
`define SPC_PCR_RX_CLOCK_POL 0
`define SPC_MODE_TX_MC_LSB 0
`define SPC_MODE_RX_MC 2
`define SPC_MODE_CLOCK_STOP_LSB 3
`define SPC_MODE_LOOPBACK 5
`define SPC_MODE_FSYNC_GEN 6
`define SPC_MODE_GEN_SYNC 7
`define SPC_GEN_DIV_LSB 0
`define SPC_GEN_DIV_W 8
`define SPC_GEN_CLOCK_SELECT 8
`define SPC_PIN_TX_CLOCK 0
`define SPC_PIN_RX_CLOCK 1
`define SPC_PIN_TX_FSYNC 2
`define SPC_PIN_RX_FSYNC 3
`define SPC_PIN_COUNT 4
`endif

// ==== rtl/spc_pin_ctrl.sv ====
// pin control, sample-rate generator clock and channel enables of a multichannel serial port
// assumes one 10 MHz clock, asynchronous active-low reset, pins resolved by the surroundings
`timescale 1ns/1ps
`include "spc_defines.svh"

// Operation
// RL1: tx mode 01: enable bit 0 disables and masks channel, 1 enables and unmasks.
// RL2: tx mode 10: all channels enabled; enable bit only masks or unmasks.
// RL3: tx mode 11: cleared bit keeps data off pin; set needs rx enable too.
// RL4: tx partition-B enables only act when tx multichannel mode is nonzero.
// RL5: tx fsync mode 0 takes pin; 1 takes internal sync per generation mode.
// RL6: rx fsync mode 1 uses generator, pin outputs it unless generator sync on.
// RL7: outside clock stop, tx clock mode picks pin input or generator output.
// RL8: clock stop: mode 0 SPI slave, 1 SPI master; rx clock follows tx.
// RL9: loopback off: rx clock mode 0 pin input, 1 generator drives pin.
// RL10: loopback on: rx clock from tx clock; pin driven only when mode is 1.
// RL11: generator clock is input clock divided by divider plus one.
// RL12: input mode and clock select choose none, system, rx pin or tx pin.
// RL13: tx fsync polarity 0 active high, 1 active low on the pin.
// RL14: rx fsync polarity 0 active high, 1 active low on the pin.
// RL15: tx clock polarity 0 samples on rising edge, 1 on falling edge.
// RL16: rx clock polarity 0 samples on falling edge, 1 on rising edge.
// RL17: rx selection mode: partition-C bit 0 disables, 1 enables its channel.
// RL18: software sets tx clock pin direction to match SPI master or slave.
// RL19: tx mode 11 makes the transmitter use the receive block assignments.
// RL20: reserved pin control bits read zero; all registers clear on reset.
module spc_pin_ctrl (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [`SPC_ADDR_W-1:0] reg_addr,
	input wire logic [`SPC_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`SPC_DATA_W-1:0] reg_rdata,
	input wire logic tx_clock_pin_in,
	output logic tx_clock_pin_out,
	output logic tx_clock_pin_oe,
	input wire logic rx_clock_pin_in,
	output logic rx_clock_pin_out,
	output logic rx_clock_pin_oe,
	input wire logic tx_fsync_pin_in,
	output logic tx_fsync_pin_out,
	output logic tx_fsync_pin_oe,
	input wire logic rx_fsync_pin_in,
	output logic rx_fsync_pin_out,
	output logic rx_fsync_pin_oe,
	input wire logic gen_frame_pulse,
	input wire logic tx_frame_request,
	input wire logic [15:0] rx_enable_mapped_b,
	output logic generator_clock,
	output logic internal_tx_clock,
	output logic internal_rx_clock,
	output logic tx_fsync_int,
	output logic rx_fsync_int,
	output logic tx_sample_pulse,
	output logic rx_sample_pulse,
	output logic [15:0] tx_chan_enable_b,
	output logic [15:0] tx_chan_unmask_b,
	output logic [15:0] tx_chan_drive_b,
	output logic tx_use_rx_blocks,
	output logic [15:0] rx_chan_enable_c,
	output logic spi_master,
	output logic spi_slave
);
	// register file
	logic [15:0] tx_chan_enable_part_b;
	logic [15:0] pin_control;
	logic [15:0] rx_chan_enable_part_c;
	logic [15:0] mode_control;
	logic [15:0] gen_config;
	logic [15:0] next_tx_chan_enable_part_b;
	logic [15:0] next_pin_control;
	logic [15:0] next_rx_chan_enable_part_c;
	logic [15:0] next_mode_control;
	logic [15:0] next_gen_config;
	logic [15:0] next_reg_rdata;

	// pin synchronisers
	logic [`SPC_PIN_COUNT-1:0] pin_raw;
	logic [`SPC_PIN_COUNT-1:0] sync_a;
	logic [`SPC_PIN_COUNT-1:0] sync_b;
	logic [`SPC_PIN_COUNT-1:0] sync_c;
	logic [`SPC_PIN_COUNT-1:0] pin_filt;
	logic [`SPC_PIN_COUNT-1:0] pin_filt_d;
	logic [`SPC_PIN_COUNT-1:0] next_pin_filt;

	// generator
	logic [`SPC_GEN_DIV_W-1:0] gen_count;
	logic [`SPC_GEN_DIV_W-1:0] next_gen_count;
	logic next_generator_clock;
	logic gen_tick;
	spc_pkg::spc_gen_src_t gen_src;

	// derived controls
	spc_pkg::spc_tx_mc_t tx_mc;
	logic clock_stop;
	logic loopback;
	logic [`SPC_GEN_DIV_W-1:0] divider;

	// registered pin and channel outputs
	logic next_internal_tx_clock;
	logic next_internal_rx_clock;
	logic next_tx_fsync_int;
	logic next_rx_fsync_int;
	logic next_tx_sample_pulse;
	logic next_rx_sample_pulse;
	logic next_tx_clock_pin_out;
	logic next_tx_clock_pin_oe;
	logic next_rx_clock_pin_out;
	logic next_rx_clock_pin_oe;
	logic next_tx_fsync_pin_out;
	logic next_tx_fsync_pin_oe;
	logic next_rx_fsync_pin_out;
	logic next_rx_fsync_pin_oe;
	logic [15:0] next_tx_chan_enable_b;
	logic [15:0] next_tx_chan_unmask_b;
	logic [15:0] next_tx_chan_drive_b;
	logic next_tx_use_rx_blocks;
	logic [15:0] next_rx_chan_enable_c;
	logic next_spi_master;
	logic next_spi_slave;

	function automatic logic [15:0] spc_masked_write(input logic [15:0] old_value,
		input logic [15:0] data, input logic [15:0] mask);
		spc_masked_write = (old_value & ~mask) | (data & mask);
	endfunction : spc_masked_write

	// one-cycle pulse on the chosen edge of a level seen on two successive cycles
	function automatic logic spc_edge(input logic old_level, input logic new_level, input logic on_fall);
		if (on_fall) begin
			spc_edge = old_level & ~new_level;
		end else begin
			spc_edge = ~old_level & new_level;
		end
	endfunction : spc_edge

	assign pin_raw = {rx_fsync_pin_in, tx_fsync_pin_in, rx_clock_pin_in, tx_clock_pin_in};
	assign tx_mc = spc_pkg::spc_tx_mc_t'(mode_control[`SPC_MODE_TX_MC_LSB +: 2]);
	assign clock_stop = mode_control[`SPC_MODE_CLOCK_STOP_LSB + 1];
	assign loopback = mode_control[`SPC_MODE_LOOPBACK];
	assign divider = gen_config[`SPC_GEN_DIV_LSB +: `SPC_GEN_DIV_W];
	assign gen_src = spc_pkg::spc_gen_src_t'({pin_control[`SPC_PCR_GEN_INPUT_MODE_EXT],
		gen_config[`SPC_GEN_CLOCK_SELECT]});

	// register writes and read-back
	always_comb begin
		next_tx_chan_enable_part_b = tx_chan_enable_part_b;
		next_pin_control = pin_control;
		next_rx_chan_enable_part_c = rx_chan_enable_part_c;
		next_mode_control = mode_control;
		next_gen_config = gen_config;
		next_reg_rdata = 16'h0000;
		if (reg_wr) begin
			case (reg_addr)
				`SPC_ADDR_TX_CHAN_EN_B: next_tx_chan_enable_part_b = reg_wdata;
				`SPC_ADDR_PIN_CONTROL: next_pin_control = spc_masked_write(pin_control, reg_wdata,
					`SPC_PIN_CONTROL_WMASK); // RL20
				`SPC_ADDR_RX_CHAN_EN_C: next_rx_chan_enable_part_c = reg_wdata;
				`SPC_ADDR_MODE_CONTROL: next_mode_control = spc_masked_write(mode_control, reg_wdata,
					`SPC_MODE_CONTROL_WMASK);
				`SPC_ADDR_GEN_CONFIG: next_gen_config = spc_masked_write(gen_config, reg_wdata,
					`SPC_GEN_CONFIG_WMASK);
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				`SPC_ADDR_TX_CHAN_EN_B: next_reg_rdata = tx_chan_enable_part_b;
				`SPC_ADDR_PIN_CONTROL: next_reg_rdata = pin_control & `SPC_PIN_CONTROL_WMASK; // RL20
				`SPC_ADDR_RX_CHAN_EN_C: next_reg_rdata = rx_chan_enable_part_c;
				`SPC_ADDR_MODE_CONTROL: next_reg_rdata = mode_control & `SPC_MODE_CONTROL_WMASK;
				`SPC_ADDR_GEN_CONFIG: next_reg_rdata = gen_config & `SPC_GEN_CONFIG_WMASK;
				`SPC_ADDR_STATUS: next_reg_rdata = {9'h000, spi_slave, spi_master, rx_fsync_int,
					tx_fsync_int, internal_rx_clock, internal_tx_clock, generator_clock};
				default: next_reg_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tx_chan_enable_part_b <= `SPC_RST_TX_CHAN_EN_B; // RL20
			pin_control <= `SPC_RST_PIN_CONTROL;
			rx_chan_enable_part_c <= `SPC_RST_RX_CHAN_EN_C;
			mode_control <= `SPC_RST_MODE_CONTROL;
			gen_config <= `SPC_RST_GEN_CONFIG;
			reg_rdata <= 16'h0000;
		end else begin
			tx_chan_enable_part_b <= next_tx_chan_enable_part_b;
			pin_control <= next_pin_control;
			rx_chan_enable_part_c <= next_rx_chan_enable_part_c;
			mode_control <= next_mode_control;
			gen_config <= next_gen_config;
			reg_rdata <= next_reg_rdata;
		end
	end

	// three-stage synchronisers; a pin level counts once stages two and three agree
	always_comb begin
		next_pin_filt = pin_filt;
		for (int i = 0; i < `SPC_PIN_COUNT; i++) begin
			if (sync_b[i] == sync_c[i]) begin
				next_pin_filt[i] = sync_c[i];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			// stages reset low like idle pins, so no false edge follows reset
			sync_a <= '0;
			sync_b <= '0;
			sync_c <= '0;
			pin_filt <= '0;
			pin_filt_d <= '0;
		end else begin
			sync_a <= pin_raw;
			sync_b <= sync_a;
			sync_c <= sync_b;
			pin_filt <= next_pin_filt;
			pin_filt_d <= pin_filt;
		end
	end

	// sample-rate generator: one period per divider+1 input ticks
	always_comb begin
		case (gen_src)
			spc_pkg::SPC_GEN_SYS: gen_tick = 1'b1; // RL12
			spc_pkg::SPC_GEN_RX_PIN: gen_tick = spc_edge(pin_filt_d[`SPC_PIN_RX_CLOCK],
				pin_filt[`SPC_PIN_RX_CLOCK], 1'b0);
			spc_pkg::SPC_GEN_TX_PIN: gen_tick = spc_edge(pin_filt_d[`SPC_PIN_TX_CLOCK],
				pin_filt[`SPC_PIN_TX_CLOCK], 1'b0);
			default: gen_tick = 1'b0;
		endcase
		next_gen_count = gen_count;
		if (gen_tick) begin
			if (gen_count >= divider) begin
				next_gen_count = '0; // RL11
			end else begin
				next_gen_count = 8'(gen_count + 8'h01);
			end
		end
		// a zero divider holds the clock high: the input rate cannot show as a level
		next_generator_clock = (next_gen_count <= (divider >> 1)); // RL11
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			gen_count <= '0;
			generator_clock <= 1'b0;
		end else begin
			gen_count <= next_gen_count;
			generator_clock <= next_generator_clock;
		end
	end

	// clock, frame-sync and pin direction selection
	// clock pins carry the internal level; the polarity bits only pick the sampling edge
	always_comb begin
		if (pin_control[`SPC_PCR_TX_CLOCK_MODE]) begin
			next_internal_tx_clock = generator_clock; // RL7 RL8
		end else begin
			next_internal_tx_clock = pin_filt[`SPC_PIN_TX_CLOCK]; // RL7 RL8
		end
		next_tx_clock_pin_oe = pin_control[`SPC_PCR_TX_CLOCK_MODE]; // RL7 RL18
		next_tx_clock_pin_out = next_internal_tx_clock;
		// in clock stop and loopback the receiver runs from the transmit clock
		if (clock_stop || loopback) begin
			next_internal_rx_clock = next_internal_tx_clock; // RL8 RL10
		end else if (pin_control[`SPC_PCR_RX_CLOCK_MODE]) begin
			next_internal_rx_clock = generator_clock; // RL9
		end else begin
			next_internal_rx_clock = pin_filt[`SPC_PIN_RX_CLOCK]; // RL9
		end
		next_rx_clock_pin_oe = pin_control[`SPC_PCR_RX_CLOCK_MODE]; // RL9 RL10
		next_rx_clock_pin_out = next_internal_rx_clock;
		next_spi_master = clock_stop & pin_control[`SPC_PCR_TX_CLOCK_MODE]; // RL8
		next_spi_slave = clock_stop & ~pin_control[`SPC_PCR_TX_CLOCK_MODE]; // RL8
		next_tx_sample_pulse = spc_edge(internal_tx_clock, next_internal_tx_clock,
			pin_control[`SPC_PCR_TX_CLOCK_POL]); // RL15
		next_rx_sample_pulse = spc_edge(internal_rx_clock, next_internal_rx_clock,
			~pin_control[`SPC_PCR_RX_CLOCK_POL]); // RL16
		if (pin_control[`SPC_PCR_TX_FSYNC_MODE]) begin
			next_tx_fsync_int = mode_control[`SPC_MODE_FSYNC_GEN] ? gen_frame_pulse : tx_frame_request; // RL5
		end else begin
			next_tx_fsync_int = pin_filt[`SPC_PIN_TX_FSYNC] ^ pin_control[`SPC_PCR_TX_FSYNC_POL]; // RL5 RL13
		end
		next_tx_fsync_pin_oe = pin_control[`SPC_PCR_TX_FSYNC_MODE];
		next_tx_fsync_pin_out = next_tx_fsync_int ^ pin_control[`SPC_PCR_TX_FSYNC_POL]; // RL13
		if (pin_control[`SPC_PCR_RX_FSYNC_MODE]) begin
			next_rx_fsync_int = gen_frame_pulse; // RL6
		end else begin
			next_rx_fsync_int = pin_filt[`SPC_PIN_RX_FSYNC] ^ pin_control[`SPC_PCR_RX_FSYNC_POL]; // RL6 RL14
		end
		next_rx_fsync_pin_oe = pin_control[`SPC_PCR_RX_FSYNC_MODE] & ~mode_control[`SPC_MODE_GEN_SYNC]; // RL6
		next_rx_fsync_pin_out = next_rx_fsync_int ^ pin_control[`SPC_PCR_RX_FSYNC_POL]; // RL14
	end

	// channel enables and masks
	always_comb begin
		case (tx_mc)
			spc_pkg::SPC_MC_SELECT: begin
				next_tx_chan_enable_b = tx_chan_enable_part_b; // RL1
				next_tx_chan_unmask_b = tx_chan_enable_part_b; // RL1
			end
			spc_pkg::SPC_MC_MASK_ONLY: begin
				next_tx_chan_enable_b = 16'hFFFF; // RL2
				next_tx_chan_unmask_b = tx_chan_enable_part_b; // RL2
			end
			spc_pkg::SPC_MC_SYMMETRIC: begin
				next_tx_chan_enable_b = rx_enable_mapped_b; // RL3
				next_tx_chan_unmask_b = tx_chan_enable_part_b; // RL3
			end
			default: begin
				next_tx_chan_enable_b = 16'hFFFF; // RL4
				next_tx_chan_unmask_b = 16'hFFFF; // RL4
			end
		endcase
		next_tx_chan_drive_b = next_tx_chan_enable_b & next_tx_chan_unmask_b; // RL3
		// mode 11 also hands the receive block assignments to the transmitter
		next_tx_use_rx_blocks = (tx_mc == spc_pkg::SPC_MC_SYMMETRIC); // RL19
		next_rx_chan_enable_c = mode_control[`SPC_MODE_RX_MC] ? rx_chan_enable_part_c : 16'hFFFF; // RL17
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			internal_tx_clock <= 1'b0;
			internal_rx_clock <= 1'b0;
			tx_fsync_int <= 1'b0;
			rx_fsync_int <= 1'b0;
			tx_sample_pulse <= 1'b0;
			rx_sample_pulse <= 1'b0;
			tx_clock_pin_out <= 1'b0;
			tx_clock_pin_oe <= 1'b0;
			rx_clock_pin_out <= 1'b0;
			rx_clock_pin_oe <= 1'b0;
			tx_fsync_pin_out <= 1'b0;
			tx_fsync_pin_oe <= 1'b0;
			rx_fsync_pin_out <= 1'b0;
			rx_fsync_pin_oe <= 1'b0;
			// reset leaves every channel enabled and unmasked, as mode zero asks
			tx_chan_enable_b <= 16'hFFFF;
			tx_chan_unmask_b <= 16'hFFFF;
			tx_chan_drive_b <= 16'hFFFF;
			tx_use_rx_blocks <= 1'b0;
			rx_chan_enable_c <= 16'hFFFF;
			spi_master <= 1'b0;
			spi_slave <= 1'b0;
		end else begin
			internal_tx_clock <= next_internal_tx_clock;
			internal_rx_clock <= next_internal_rx_clock;
			tx_fsync_int <= next_tx_fsync_int;
			rx_fsync_int <= next_rx_fsync_int;
			tx_sample_pulse <= next_tx_sample_pulse;
			rx_sample_pulse <= next_rx_sample_pulse;
			tx_clock_pin_out <= next_tx_clock_pin_out;
			tx_clock_pin_oe <= next_tx_clock_pin_oe;
			rx_clock_pin_out <= next_rx_clock_pin_out;
			rx_clock_pin_oe <= next_rx_clock_pin_oe;
			tx_fsync_pin_out <= next_tx_fsync_pin_out;
			tx_fsync_pin_oe <= next_tx_fsync_pin_oe;
			rx_fsync_pin_out <= next_rx_fsync_pin_out;
			rx_fsync_pin_oe <= next_rx_fsync_pin_oe;
			tx_chan_enable_b <= next_tx_chan_enable_b;
			tx_chan_unmask_b <= next_tx_chan_unmask_b;
			tx_chan_drive_b <= next_tx_chan_drive_b;
			tx_use_rx_blocks <= next_tx_use_rx_blocks;
			rx_chan_enable_c <= next_rx_chan_enable_c;
			spi_master <= next_spi_master;
			spi_slave <= next_spi_slave;
		end
	end
endmodule : spc_pin_ctrl

// ==== rtl/spc_pkg.sv ====
// types shared by the serial port pin control block
// assumes nothing of its surroundings
package spc_pkg;
	typedef enum logic [1:0] {
		SPC_MC_ALL = 2'h0,
		SPC_MC_SELECT = 2'h1,
		SPC_MC_MASK_ONLY = 2'h2,
		SPC_MC_SYMMETRIC = 2'h3
	} spc_tx_mc_t;
	typedef enum logic [1:0] {
		SPC_GEN_NONE = 2'h0,
		SPC_GEN_SYS = 2'h1,
		SPC_GEN_RX_PIN = 2'h2,
		SPC_GEN_TX_PIN = 2'h3
	} spc_gen_src_t;
endpackage : spc_pkg

// ==== verification/spc_codec_model.sv ====
// external codec: bit clock master while running, frame sync level on request
// assumes the bench resolves each pin from this model and the block's enables
`timescale 1ns/1ps
module spc_codec_model (
	input wire logic clk_sys,
	input wire logic run,
	input wire logic fs_level,
	output logic codec_clk,
	output logic codec_fs
);
	logic [1:0] div;
	// bit clock stands low between frames, eight system cycles a period
	always_ff @(posedge clk_sys) begin
		div <= run ? div + 2'h1 : 2'h0;
		if (!run)
			codec_clk <= 1'b0;
		else if (div == 2'h3)
			codec_clk <= ~codec_clk;
	end
	assign codec_fs = fs_level;
endmodule : spc_codec_model

// ==== verification/spc_pin_ctrl_bench.sv ====
// self-checking bench of the pin control block with a codec model on its pins
// assumes the design and package files compiled before it
`timescale 1ns/1ps
module spc_pin_ctrl_bench;
	logic clk_sys, resetn, reg_wr, reg_rd, gen_frame_pulse, tx_frame_request, run, fs_level;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, rx_enable_mapped_b, reg_rdata, tx_chan_enable_b, tx_chan_unmask_b;
	logic [15:0] tx_chan_drive_b, rx_chan_enable_c, d, en, un;
	logic tx_clock_pin_out, tx_clock_pin_oe, rx_clock_pin_out, rx_clock_pin_oe, tx_fsync_pin_out;
	logic tx_fsync_pin_oe, rx_fsync_pin_out, rx_fsync_pin_oe, generator_clock, internal_tx_clock;
	logic internal_rx_clock, tx_fsync_int, rx_fsync_int, tx_sample_pulse, rx_sample_pulse;
	logic tx_use_rx_blocks, spi_master, spi_slave, codec_clk, codec_fs, pt, pr;
	int n_mismatch = 0;
	int num_checks = 0;
	int c;
	wire tx_clock_pin_in = tx_clock_pin_oe ? tx_clock_pin_out : codec_clk;
	wire rx_clock_pin_in = rx_clock_pin_oe ? rx_clock_pin_out : codec_clk;
	wire tx_fsync_pin_in = tx_fsync_pin_oe ? tx_fsync_pin_out : codec_fs;
	wire rx_fsync_pin_in = rx_fsync_pin_oe ? rx_fsync_pin_out : codec_fs;
	spc_pin_ctrl spc_pin_ctrl_i (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.tx_clock_pin_in, .tx_clock_pin_out, .tx_clock_pin_oe, .rx_clock_pin_in, .rx_clock_pin_out,
		.rx_clock_pin_oe, .tx_fsync_pin_in, .tx_fsync_pin_out, .tx_fsync_pin_oe, .rx_fsync_pin_in,
		.rx_fsync_pin_out, .rx_fsync_pin_oe, .gen_frame_pulse, .tx_frame_request, .rx_enable_mapped_b,
		.generator_clock, .internal_tx_clock, .internal_rx_clock, .tx_fsync_int, .rx_fsync_int,
		.tx_sample_pulse, .rx_sample_pulse, .tx_chan_enable_b, .tx_chan_unmask_b, .tx_chan_drive_b,
		.tx_use_rx_blocks, .rx_chan_enable_c, .spi_master, .spi_slave);
	spc_codec_model spc_codec_model_i (.clk_sys, .run, .fs_level, .codec_clk, .codec_fs);
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	task check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	// pin levels need five edges to reach the internal outputs
	task settle;
		repeat (6) @(posedge clk_sys);
		#1;
	endtask : settle
	task count_high(input int sel, input int n);
		c = 0;
		repeat (n) begin
			@(posedge clk_sys);
			#1 c += sel == 0 ? generator_clock : sel == 1 ? tx_clock_pin_out :
				sel == 2 ? internal_rx_clock : rx_clock_pin_out;
		end
	endtask : count_high
	task t_registers;
		for (int a = 8'h11; a <= 8'h13; a++) begin
			rd(8'(a), d);
			check(d, 16'h0000);
			wr(8'(a), 16'hFFFF);
			rd(8'(a), d);
			check(d, a == 8'h12 ? 16'h0F8F : 16'hFFFF);
		end
		rd(8'h30, d);
		check(d, 16'h0000);
	endtask : t_registers
	task t_channels;
		wr(8'h11, 16'hA5C3);
		wr(8'h13, 16'h3C5A);
		rx_enable_mapped_b <= 16'h0FF0;
		for (int m = 0; m < 4; m++) begin
			wr(8'h20, {13'h0000, m[0], m[1:0]});
			settle;
			en = m[0] == 1'b0 ? 16'hFFFF : m == 1 ? 16'hA5C3 : 16'h0FF0;
			un = m == 0 ? 16'hFFFF : 16'hA5C3;
			check(tx_chan_enable_b, en);
			check(tx_chan_unmask_b, un);
			check(tx_chan_drive_b, en & un);
			check(16'(tx_use_rx_blocks), 16'(m == 3));
			check(rx_chan_enable_c, m[0] ? 16'h3C5A : 16'hFFFF);
		end
	endtask : t_channels
	task t_edges;
		wr(8'h20, 16'h0000);
		run <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			wr(8'h12, p == 1 ? 16'h0003 : 16'h0000);
			settle;
			pt = internal_tx_clock;
			pr = internal_rx_clock;
			repeat (24) begin
				@(posedge clk_sys);
				#1 check(16'(tx_sample_pulse), 16'(p ? pt & ~internal_tx_clock : ~pt & internal_tx_clock));
				check(16'(rx_sample_pulse), 16'(p ? ~pr & internal_rx_clock : pr & ~internal_rx_clock));
				pt = internal_tx_clock;
				pr = internal_rx_clock;
			end
		end
	endtask : t_edges
	task t_clocks;
		wr(8'h21, 16'h0104);
		wr(8'h12, 16'h0200);
		settle;
		check(16'(tx_clock_pin_oe), 16'h0001);
		count_high(0, 10);
		check(16'(c), 16'h0006);
		count_high(1, 10);
		check(16'(c), 16'h0006);
		wr(8'h20, 16'h0020);
		settle;
		check(16'(rx_clock_pin_oe), 16'h0000);
		count_high(2, 10);
		check(16'(c), 16'h0006);
		wr(8'h12, 16'h0300);
		settle;
		check(16'(rx_clock_pin_oe), 16'h0001);
		count_high(3, 10);
		check(16'(c), 16'h0006);
		wr(8'h20, 16'h0010);
		settle;
		check(16'({spi_master, spi_slave}), 16'h0002);
		wr(8'h12, 16'h0000);
		settle;
		check(16'({spi_master, spi_slave, tx_clock_pin_oe}), 16'h0002);
		repeat (16) begin
			@(posedge clk_sys);
			#1 check(16'(internal_rx_clock), 16'(internal_tx_clock));
		end
		wr(8'h20, 16'h0000);
		wr(8'h21, 16'h0001);
		wr(8'h12, 16'h0080);
		settle;
		count_high(0, 32);
		check(16'(c), 16'h0010);
		run <= 1'b0;
	endtask : t_clocks
	task t_fsync;
		wr(8'h20, 16'h0040);
		wr(8'h12, 16'h080C);
		gen_frame_pulse <= 1'b1;
		fs_level <= 1'b0;
		settle;
		check(16'({tx_fsync_pin_oe, tx_fsync_int}), 16'h0003);
		check(16'(tx_fsync_pin_out), 16'h0000);
		check(16'({rx_fsync_int, rx_fsync_pin_oe}), 16'h0002);
		wr(8'h12, 16'h0C0C);
		settle;
		check(16'({rx_fsync_pin_oe, rx_fsync_pin_out, rx_fsync_int}), 16'h0005);
		wr(8'h20, 16'h00C0);
		settle;
		check(16'(rx_fsync_pin_oe), 16'h0000);
		rd(8'h22, d);
		check(d & 16'h0078, 16'h0018);
		gen_frame_pulse <= 1'b0;
		tx_frame_request <= 1'b1;
		wr(8'h20, 16'h0000);
		settle;
		check(16'(tx_fsync_int), 16'h0001);
		fs_level <= 1'b1;
		wr(8'h12, 16'h0008);
		settle;
		check(16'({tx_fsync_pin_oe, tx_fsync_int}), 16'h0000);
	endtask : t_fsync
	initial begin
		resetn = 1'b0;
		{reg_wr, reg_rd, gen_frame_pulse, tx_frame_request, run, fs_level} = 6'h00;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		rx_enable_mapped_b = 16'h0000;
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		t_registers;
		t_channels;
		t_edges;
		t_clocks;
		t_fsync;
		stop_test;
	end
	initial begin
		#(5000 * 100);
		n_mismatch++;
		stop_test;
	end
endmodule : spc_pin_ctrl_bench

// ==== verification/spc_pin_ctrl_props.sv ====
// concurrent checks on the pin control block's ports
// assumes one clock domain and registered outputs one edge after a register write
`timescale 1ns/1ps
module spc_pin_ctrl_props (
	input logic clk_sys,
	input logic resetn,
	input logic [7:0] reg_addr,
	input logic [15:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	input logic [15:0] reg_rdata,
	input logic tx_clock_pin_oe,
	input logic rx_clock_pin_oe,
	input logic tx_fsync_pin_oe,
	input logic internal_tx_clock,
	input logic internal_rx_clock,
	input logic tx_sample_pulse,
	input logic rx_sample_pulse,
	input logic [15:0] tx_chan_enable_b,
	input logic [15:0] tx_chan_unmask_b,
	input logic [15:0] tx_chan_drive_b,
	input logic spi_master,
	input logic spi_slave
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	// a pin control write not followed at once by another one
	sequence pcr_wr;
		reg_wr && reg_addr == 8'h12 ##1 !(reg_wr && reg_addr == 8'h12);
	endsequence
	// a mode write selecting mode 00 or 10, not followed at once by another one
	sequence mode_wr;
		reg_wr && reg_addr == 8'h20 && !reg_wdata[0] ##1 !(reg_wr && reg_addr == 8'h20);
	endsequence
	chk_tx_clk_dir: assert property (pcr_wr |-> ##1 tx_clock_pin_oe == $past(reg_wdata[9], 2))
		else $error("tx clock pin direction wrong");
	chk_rx_clk_dir: assert property (pcr_wr |-> ##1 rx_clock_pin_oe == $past(reg_wdata[8], 2))
		else $error("rx clock pin direction wrong");
	chk_tx_fs_dir: assert property (pcr_wr |-> ##1 tx_fsync_pin_oe == $past(reg_wdata[11], 2))
		else $error("tx frame sync pin direction wrong");
	chk_all_enabled: assert property (mode_wr |-> ##1 tx_chan_enable_b == 16'hFFFF)
		else $error("tx channels not all enabled");
	chk_reserved_zero: assert property (reg_rd && reg_addr == 8'h12 |=> reg_rdata[15:12] == 4'h0 && reg_rdata[6:4] == 3'h0)
		else $error("reserved pin control bits not zero");
	chk_drive_and: assert property (tx_chan_drive_b == (tx_chan_enable_b & tx_chan_unmask_b))
		else $error("tx drive not enable and unmask");
	chk_spi_master: assert property (spi_master |-> tx_clock_pin_oe && !spi_slave)
		else $error("spi master role inconsistent");
	chk_spi_slave: assert property (spi_slave |-> !tx_clock_pin_oe)
		else $error("spi slave drives clock pin");
	chk_tx_sample_edge: assert property (tx_sample_pulse |-> $changed(internal_tx_clock))
		else $error("tx sample without clock edge");
	chk_rx_sample_edge: assert property (rx_sample_pulse |-> $changed(internal_rx_clock))
		else $error("rx sample without clock edge");
endmodule : spc_pin_ctrl_props

bind spc_pin_ctrl spc_pin_ctrl_props spc_pin_ctrl_props_i (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .tx_clock_pin_oe, .rx_clock_pin_oe, .tx_fsync_pin_oe, .internal_tx_clock,
	.internal_rx_clock, .tx_sample_pulse, .rx_sample_pulse, .tx_chan_enable_b, .tx_chan_unmask_b,
	.tx_chan_drive_b, .spi_master, .spi_slave);
